// *** logic/isb_pkg.sv ***
// Purpose: shared constants and types for the interleaved static-column burst controller
// Assumes: one 200 MHz clock; the bus cycle is a fixed number of mclk ticks
// Notes:   bank select is the lowest word-address bit

package isb_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 21;
  localparam int DATA_W = 32;
  localparam int COL_W = 10;
  localparam int ROW_W = 10;
  localparam int NBANK = 2;
  localparam int PH_W = 3;
  localparam int COL_LSB = 1;
  localparam int ROW_LSB = 11;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int BUS_PERIOD_NS = 40;
  localparam int BUS_DIV = BUS_PERIOD_NS / CLK_PERIOD_NS;
  localparam int RAS_DLY_NS = 16;
  // least time, rounded up to whole ticks
  localparam int RAS_DLY_CYC = (RAS_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC = 2;
  localparam int FIRST_CYC = 4;
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(BUS_DIV - 1);
  localparam logic [PH_W-1:0] PH_MUX = PH_W'(RAS_DLY_CYC - 1);
  localparam logic [PH_W-1:0] PH_ZERO = 3'h0;
  localparam logic [PH_W-1:0] PH_ONE = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 21'h000001;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ROW = 3'h1,
    ST_ACC1 = 3'h3,
    ST_ACC2 = 3'h2,
    ST_BURST = 3'h6,
    ST_PRE = 3'h4
  } isb_state_e;

  typedef struct packed {
    logic req_n;
    logic breq_n;
  } isb_req_s;

  typedef struct packed {
    logic rdy;
    logic back;
  } isb_resp_s;

  typedef struct packed {
    logic [NBANK-1:0] ras_n;
    logic [NBANK-1:0] cas_n;
    logic mux_col;
    logic [NBANK-1:0][COL_W-1:0] addr;
  } isb_dram_s;

  typedef struct packed {
    isb_state_e st;
    logic [PH_W-1:0] phase;
    logic [ADDR_W-1:0] cnt;
    logic is_data;
    isb_resp_s iresp;
    isb_resp_s dresp;
    logic [DATA_W-1:0] rdata;
    isb_dram_s dram;
  } isb_state_s;

endpackage

// *** logic/isb_burst_ctrl.sv ***
// Purpose: two-bank interleaved static-column dram controller for burst reads
// Assumes: requests and bank data come from logic on mclk; refresh and writes live elsewhere
// Notes:   one bus cycle is BUS_DIV ticks of mclk, marked by the phase divider

`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - decode cycle samples the request, then loads the address counter.
// - row address shown from start of the next cycle, column later in it.
// - row strobe goes low in row cycle; a timed delay then selects column.
// - first bank access takes two bus cycles after the row cycle.
// - first word is delivered at the end of the fourth bus cycle.
// - every later bank access in a burst also lasts two bus cycles.
// - banks alternate so one burst word arrives every bus cycle.
// - response outputs are registered and valid in every cycle, decode too.
// - with instruction requests idle, data requests alone are served.
module isb_burst_ctrl
  import isb_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // processor requests
  input wire isb_req_s ireq,
  input wire isb_req_s dreq,
  input wire logic [ADDR_W-1:0] req_addr,
  // bank read data
  input wire logic [NBANK-1:0][DATA_W-1:0] bank_rdata,
  // processor responses
  output isb_resp_s iresp,
  output isb_resp_s dresp,
  output logic [DATA_W-1:0] rdata,
  // dram array
  output isb_dram_s dram
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  isb_state_s s;
  isb_state_s next_s;
  logic tick;
  logic want_i;
  logic want_d;
  logic load;
  logic deliver;
  logic go_on;
  logic cur_breq;
  logic [ADDR_W-1:0] next_cnt;
  logic next_mux;
  logic [NBANK-1:0][COL_W-1:0] next_addr;

  assign tick = (s.phase == PH_LAST);
  assign want_i = !ireq.req_n;
  assign want_d = !dreq.req_n;
  assign load = tick && (s.st == ST_IDLE) && (want_i || want_d);
  assign deliver = tick && ((s.st == ST_ACC2) || (s.st == ST_BURST));
  assign cur_breq = s.is_data ? !dreq.breq_n : !ireq.breq_n;
  // a data request ends an instruction burst; both cannot share the array
  assign go_on = cur_breq && !(!s.is_data && want_d);
  assign next_cnt = load ? req_addr : (deliver ? s.cnt + ADDR_ONE : s.cnt);
  assign next_mux = ((s.st == ST_ROW) && (s.phase == PH_MUX)) || (s.dram.mux_col && !(deliver && !go_on));

  // ------------------------------------------------------------
  // per-bank address
  // ------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < NBANK; b++) begin : g_bank
      logic [ADDR_W-1:0] word;
      // each bank holds its next word
      assign word = next_cnt + ((next_cnt[0] != 1'(b)) ? ADDR_ONE : '0);
      assign next_addr[b] = next_mux ? word[COL_LSB +: COL_W] : next_cnt[ROW_LSB +: ROW_W];
    end
  endgenerate

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.phase = tick ? PH_ZERO : s.phase + PH_ONE;
    next_s.cnt = next_cnt;
    next_s.dram.mux_col = next_mux;
    next_s.dram.cas_n = {NBANK{!next_mux}};
    next_s.dram.addr = next_addr;
    if (tick) begin
      next_s.iresp.rdy = 1'b0;
      next_s.dresp.rdy = 1'b0;
    end
    case (s.st)
      ST_IDLE: begin
        if (load) begin
          next_s.is_data = want_d;
          next_s.st = ST_ROW;
          next_s.dram.ras_n = '0;
        end
      end
      ST_ROW: begin
        if (tick) begin
          next_s.st = ST_ACC1;
        end
      end
      ST_ACC1: begin
        if (tick) begin
          next_s.st = ST_ACC2;
          next_s.iresp.back = !s.is_data && go_on;
          next_s.dresp.back = s.is_data && go_on;
        end
      end
      ST_ACC2, ST_BURST: begin
        if (deliver) begin
          next_s.rdata = bank_rdata[s.cnt[0]];
          next_s.iresp.rdy = !s.is_data;
          next_s.dresp.rdy = s.is_data;
          next_s.st = go_on ? ST_BURST : ST_PRE;
          next_s.iresp.back = !s.is_data && go_on;
          next_s.dresp.back = s.is_data && go_on;
          if (!go_on) begin
            next_s.dram.ras_n = '1;
          end
        end
      end
      ST_PRE: begin
        // one idle cycle lets the row strobe precharge
        if (tick) begin
          next_s.st = ST_IDLE;
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s <= '{st: ST_IDLE, phase: PH_ZERO, cnt: '0, is_data: 1'b0, iresp: '0, dresp: '0,
             rdata: '0, dram: '{ras_n: '1, cas_n: '1, mux_col: 1'b0, addr: '0}};
    end else begin
      s <= next_s;
    end
  end

  assign iresp = s.iresp;
  assign dresp = s.dresp;
  assign rdata = s.rdata;
  assign dram = s.dram;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  localparam int FIRST_DLY = (FIRST_CYC - 1) * BUS_DIV;
  localparam int ACC_DLY = ACC_CYC * BUS_DIV;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  AST_DECODE_LOAD: assert property (load |=> (s.st == ST_ROW) && (s.cnt == $past(req_addr)))
    else $error("decode did not load the counter");
  AST_ROW_FIRST: assert property ($rose(s.st == ST_ROW) |-> !s.dram.mux_col && (s.dram.addr[0] ==
    s.cnt[ROW_LSB +: ROW_W]))
    else $error("row address not shown at row cycle start");
  AST_RAS_DELAY: assert property ($rose(s.st == ST_ROW) |-> !s.dram.mux_col [*4] ##1 s.dram.mux_col)
    else $error("column select not at delay expiry");
  AST_ACC_TWO: assert property ($rose(s.st == ST_ACC1) |-> ##ACC_DLY $rose(s.iresp.rdy || s.dresp.rdy))
    else $error("first access not two cycles");
  AST_FIRST_WORD: assert property ($rose(s.st == ST_ROW) |-> ##FIRST_DLY (s.iresp.rdy || s.dresp.rdy))
    else $error("first word not after four cycles");
  AST_BURST_RATE: assert property (deliver && go_on |=> ##BUS_DIV $changed(s.cnt))
    else $error("burst word missed a cycle");
  AST_ALTERNATE: assert property (deliver |=> s.cnt[0] != $past(s.cnt[0]))
    else $error("banks did not alternate");
  AST_ONE_SIDE: assert property (!(s.iresp.rdy && s.dresp.rdy) && !(s.iresp.back && s.dresp.back))
    else $error("both response sides active");
  AST_DATA_ONLY: assert property (s.iresp.rdy |-> !s.is_data)
    else $error("instruction ready during data access");
  AST_COUNT_STEP: assert property (deliver |=> s.cnt == $past(s.cnt) + ADDR_ONE)
    else $error("counter did not step by one");

  // ------------------------------------------------------------
  // state and strobe checks
  // ------------------------------------------------------------
  AST_ROW_TO_ACC: assert property ($rose(s.st == ST_ROW) |-> ##BUS_DIV (s.st == ST_ACC1))
    else $error("row cycle not one bus cycle");
  AST_ACC1_LEN: assert property ($rose(s.st == ST_ACC1) |-> ##BUS_DIV (s.st == ST_ACC2))
    else $error("first access half not one bus cycle");
  AST_CAS_FOLLOWS_COL: assert property (s.dram.cas_n == {NBANK{!s.dram.mux_col}})
    else $error("column strobe apart from column select");
  AST_RAS_LOW_ACCESS: assert property ((s.st inside {ST_ROW, ST_ACC1, ST_ACC2, ST_BURST}) |-> (s.dram.ras_n == '0))
    else $error("row strobe high during access");
  AST_BURST_ADDR: assert property ((s.st inside {ST_ACC1, ST_ACC2, ST_BURST}) |->
    (s.dram.addr[s.cnt[0]] == s.cnt[COL_LSB +: COL_W]))
    else $error("current bank column not the counter");
  AST_RDY_STANDS: assert property ($rose(s.iresp.rdy || s.dresp.rdy) |-> (s.iresp.rdy || s.dresp.rdy) [*8])
    else $error("ready did not stand one bus cycle");
  AST_BACK_DROPS: assert property (deliver && !go_on |=> !s.iresp.back && !s.dresp.back)
    else $error("burst acknowledge kept after last word");
  AST_PRECHARGE: assert property (deliver && !go_on |=> (s.dram.ras_n == '1) && !s.dram.mux_col ##BUS_DIV
    (s.st == ST_IDLE))
    else $error("precharge cycle missing");
  AST_IDLE_QUIET: assert property ((s.st == ST_IDLE) |-> !s.iresp.rdy && !s.dresp.rdy && !s.iresp.back &&
    !s.dresp.back)
    else $error("response active while idle");
  AST_PREEMPT: assert property ((s.st == ST_BURST) && !s.is_data && want_d && tick |=> (s.st == ST_PRE))
    else $error("data request did not end instruction burst");
  AST_DATA_WINS: assert property (load && want_d |=> s.is_data)
    else $error("data request not served first");

  COV_SIMPLE: cover property ($rose(s.st == ST_PRE) && !s.iresp.back && !s.dresp.back);
  COV_BURST: cover property ((s.st == ST_BURST) [*8] ##1 (s.st == ST_BURST));
  COV_PREEMPT: cover property ((s.st == ST_BURST) && !s.is_data && want_d && tick);
  COV_DATA_BURST: cover property ((s.st == ST_BURST) && s.is_data && deliver);
  COV_MUX_SWITCH: cover property ((s.st == ST_ROW) && $rose(s.dram.mux_col));

endmodule

`default_nettype wire

// *** test/isb_bank_model.sv ***
// Purpose: behavioural model of the two interleaved static-column dram banks
// Assumes: row taken while the row strobe is low and the mux shows the row
// Notes:   released data lines show the inverse of the last word, never a held value

`timescale 1ns/1ps
`default_nettype none

module isb_bank_model
  import isb_pkg::*;
(
  // clock
  input wire logic mclk,
  // dram array
  input wire isb_dram_s dram,
  // bank read data
  output logic [NBANK-1:0][DATA_W-1:0] bank_rdata
);
  logic [NBANK-1:0][ROW_W-1:0] row = '0;
  logic [NBANK-1:0][DATA_W-1:0] last = '0;

  always_ff @(posedge mclk) begin
    for (int b = 0; b < NBANK; b++) begin
      if (!dram.ras_n[b] && !dram.mux_col) begin
        row[b] <= dram.addr[b];
      end
      last[b] <= bank_rdata[b];
    end
  end

  always_comb begin
    for (int b = 0; b < NBANK; b++) begin
      if (!dram.cas_n[b]) begin
        bank_rdata[b] = {row[b], dram.addr[b], b[0], 11'h2A5};
      end else begin
        bank_rdata[b] = ~last[b];
      end
    end
  end
endmodule

`default_nettype wire

// *** test/testbench.sv ***
// Purpose: self-checking bench for the interleaved burst controller
// Assumes: inputs driven 1 ns after the rising edge
// Notes:   columns kept below the top so bursts never wrap a row

`timescale 1ns/1ps
`default_nettype none

module testbench;
  import isb_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  isb_req_s ireq = '1;
  isb_req_s dreq = '1;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [NBANK-1:0][DATA_W-1:0] bank_rdata;
  isb_resp_s iresp;
  isb_resp_s dresp;
  logic [DATA_W-1:0] rdata;
  isb_dram_s dram;
  int error_cnt = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'h2;

  always #2.5 mclk = ~mclk;

  isb_burst_ctrl i_isb_burst_ctrl (.mclk(mclk), .nrst(nrst), .ireq(ireq), .dreq(dreq), .req_addr(req_addr),
    .bank_rdata(bank_rdata), .iresp(iresp), .dresp(dresp), .rdata(rdata), .dram(dram));
  isb_bank_model i_isb_bank_model (.mclk(mclk), .dram(dram), .bank_rdata(bank_rdata));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  function automatic logic [DATA_W-1:0] exp_word(input logic [ADDR_W-1:0] a);
    return {a[20:11], a[10:1], a[0], 11'h2A5};
  endfunction

  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (!ok) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  task automatic tick;
    @(posedge mclk);
    #1;
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one access; side_d picks the data side, nw words
  task automatic run(input logic side_d, input logic [ADDR_W-1:0] a, input int nw);
    int n;
    isb_resp_s r;
    isb_resp_s o;
    req_addr = a;
    if (side_d) begin
      dreq = {1'b0, nw == 1};
    end else begin
      ireq = {1'b0, nw == 1};
    end
    n = 0;
    while (dram.ras_n === 2'h3 && n < 40) begin
      tick;
      n++;
    end
    if (n >= 40) begin
      chk(1'b0, "no row strobe");
      test_done;
    end
    chk(dram.mux_col === 1'b0 && dram.addr[0] === a[20:11], "row address");
    n = 0;
    r = side_d ? dresp : iresp;
    while (r.rdy !== 1'b1 && n < 40) begin
      if (n == 7) chk(dram.mux_col === 1'b1 && dram.cas_n === 2'h0, "column select");
      tick;
      n++;
      r = side_d ? dresp : iresp;
    end
    chk(n == 24, "first word latency");
    if (n >= 40) test_done;
    o = side_d ? iresp : dresp;
    chk(o.rdy === 1'b0 && o.back === 1'b0, "other side quiet");
    chk(r.back === (nw > 1), "burst acknowledge");
    ireq.req_n = 1'b1;
    dreq.req_n = 1'b1;
    for (int k = 0; k < nw; k++) begin
      chk(rdata === exp_word(a + ADDR_W'(k)), "word data");
      // burst request must be gone before the tick that delivers the last word
      if (k >= nw - 2) begin
        ireq = '1;
        dreq = '1;
      end
      repeat (8) tick;
      r = side_d ? dresp : iresp;
      if (k < nw - 1) chk(r.rdy === 1'b1, "one word per bus cycle");
    end
    chk(r.rdy === 1'b0 && dram.ras_n === 2'h3, "access closed");
    $display("test done side %0d addr %h words %0d", side_d, a, nw);
  endtask

  // instruction burst cut short by a data request; starts at an idle bus cycle
  task automatic preempt(input logic [ADDR_W-1:0] a);
    int n;
    req_addr = a;
    ireq = 2'h0;
    n = 0;
    while (iresp.rdy !== 1'b1 && n < 40) begin
      tick;
      n++;
    end
    chk(n == 32, "preempt first word latency");
    if (n >= 40) test_done;
    chk(iresp.back === 1'b1 && rdata === exp_word(a), "burst before preemption");
    dreq = 2'h1;
    repeat (8) tick;
    chk(iresp.rdy === 1'b1 && iresp.back === 1'b0 && rdata === exp_word(a + ADDR_ONE), "preempted end");
    ireq = '1;
    $display("test done preempt addr %h", a);
  endtask

  initial begin
    repeat (20) @(posedge mclk);
    #1;
    nrst = 1'b1;
    run(1'b0, 21'h000000, 1);
    run(1'b1, 21'h1FF801, 4);
    run(1'b0, 21'h000001, 2);
    run(1'b1, 21'h0003FE, 1);
    preempt(21'h000410);
    run(1'b1, 21'h000A40, 1);
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      run(seed[0], seed[31:11] & 21'h1FFBFF, int'(seed[2:1]) + 1);
    end
    test_done;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    chk(1'b0, "run timed out");
    test_done;
  end
endmodule

`default_nettype wire
